/* File: hw/sr_pkg.sv */
/*
  Shared constants and carrier types for the host-side controller of a
  1K x 8 asynchronous static RAM.
  Assumes a single 250 MHz clock and a RAM wired straight to the pins.
*/
package sr_pkg;

  // ************************************************
  // array geometry
  // ************************************************
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int DEPTH  = 1024;

  // ************************************************
  // timing, slowest speed grade as default
  // ************************************************
  localparam int CLK_PS        = 4000;
  localparam int POWERUP_NS    = 500000;
  localparam int POWERUP_CYC   = (POWERUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int T_RC_NS       = 200;
  localparam int RD_CYC        = (T_RC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int T_WP_NS       = 120;
  localparam int WP_CYC        = (T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int T_WC_NS       = 200;
  localparam int WC_CYC        = (T_WC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int T_HZ_NS       = 60;
  localparam int HZ_CYC        = (T_HZ_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W         = 20;

  // ************************************************
  // reset values of the pins
  // ************************************************
  localparam logic SEL_N_RST  = 1'b1;
  localparam logic OE_N_RST   = 1'b1;
  localparam logic WE_N_RST   = 1'b1;
  localparam logic VARIANT_B  = 1'b0;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sr_req_type;

  typedef struct packed {
    logic              sel_n;
    logic              oe_n;
    logic              we_n;
    logic              ref_sel;
    logic [ADDR_W-1:0] addr;
  } sr_pins_type;

endpackage

/* File: hw/sr_host.sv */
/*
  Host-side controller driving a 1K x 8 asynchronous static RAM through
  its select, output enable, write strobe, address and shared data pins.
  Assumes the RAM pins are wired directly and the data wire is resolved
  outside from dq_oe.
*/
module sr_host
  import sr_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter bit REF_VARIANT    = VARIANT_B
)
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire sr_pkg::sr_req_type req,
  input  wire logic               req_valid,
  output logic                    req_ready,
  output logic                    rsp_valid,
  output logic [sr_pkg::DATA_W-1:0] rsp_data,
  output sr_pkg::sr_pins_type     pins,
  output logic [sr_pkg::DATA_W-1:0] dq_out,
  output logic                    dq_oe,
  input  wire logic [sr_pkg::DATA_W-1:0] dq_in
);
  import sr_pkg::*;

  typedef enum logic [2:0] {
    ST_POWERUP,
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_RECOVER
  } sr_state_type;

  sr_state_type     state;
  logic [CNT_W-1:0] count;
  logic             boot_done;
  logic             take;
  logic             rd_done;
  logic             wr_done;
  logic             rec_done;

  // ************************************************
  // phase decode
  // ************************************************
  // power-up wait ends
  assign boot_done = (state == ST_POWERUP) && (count == CNT_W'(POWERUP_CYCLES - 1));
  // only idle accepts; ready is high there and nowhere else
  assign take      = (state == ST_IDLE) && req_valid;
  // select held a full read cycle
  assign rd_done   = (state == ST_READ) && (count == CNT_W'(RD_CYC - 1));
  // strobe spans the whole write cycle, so select and
  // address also lead its end by more than their minimum
  assign wr_done   = (state == ST_WRITE) && (count == CNT_W'(WC_CYC - 1));
  // deselected long enough for the bus to float
  assign rec_done  = (state == ST_RECOVER) && (count == CNT_W'(HZ_CYC - 1));

  // ************************************************
  // sequencer
  // ************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_POWERUP;
    end
    else
    begin
      case (state)
        ST_POWERUP:
        begin
          if (boot_done)
          begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE:
        begin
          if (take)
          begin
            state <= req.write ? ST_WRITE : ST_READ;
          end
        end
        ST_READ:
        begin
          if (rd_done)
          begin
            state <= ST_RECOVER;
          end
        end
        ST_WRITE:
        begin
          if (wr_done)
          begin
            state <= ST_RECOVER;
          end
        end
        ST_RECOVER:
        begin
          if (rec_done)
          begin
            state <= ST_IDLE;
          end
        end
        default:
        begin
          state <= ST_POWERUP;
        end
      endcase
    end
  end

  // ************************************************
  // phase counter
  // ************************************************
  // one counter times every phase but idle, where it holds; cleared on each phase change
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
    end
    else if (boot_done || take || rd_done || wr_done || rec_done)
    begin
      count <= '0;
    end
    else if (state != ST_IDLE)
    begin
      count <= count + 1'b1;
    end
  end

  // ************************************************
  // request handshake
  // ************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      req_ready <= 1'b0;
    end
    else if (boot_done || rec_done)
    begin
      req_ready <= 1'b1;
    end
    else if (take)
    begin
      req_ready <= 1'b0;
    end
  end

  // ************************************************
  // read response
  // ************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end
    else
    begin
      rsp_valid <= rd_done;
      // sampled while the RAM still drives
      if (rd_done)
      begin
        rsp_data <= dq_in;
      end
    end
  end

  // ************************************************
  // control pins
  // ************************************************
  // strap held at its level in reset too, so it never toggles
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pins <= '{sel_n: SEL_N_RST, oe_n: OE_N_RST, we_n: WE_N_RST,
                ref_sel: REF_VARIANT, addr: '0};
    end
    else
    begin
      pins.ref_sel <= REF_VARIANT;
      if (take)
      begin
        // address and select move on one edge
        pins.addr  <= req.addr;
        pins.sel_n <= 1'b0;
        pins.we_n  <= ~req.write;
        pins.oe_n  <= req.write;
      end
      else if (rd_done || wr_done)
      begin
        pins.sel_n <= 1'b1;
        pins.oe_n  <= 1'b1;
        pins.we_n  <= 1'b1;
      end
    end
  end

  // ************************************************
  // data bus
  // ************************************************
  // data held one beat past the strobe, then the bus is freed
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end
    else if (take && req.write)
    begin
      dq_out <= req.wdata;
      dq_oe  <= 1'b1;
    end
    else if (state == ST_RECOVER)
    begin
      dq_oe <= 1'b0;
    end
  end

endmodule

/* File: test/sr_host_checker.sv */
/* pin-timing assertions for sr_host; bound to every sr_host instance */
module sr_host_checker
  import sr_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter bit REF_VARIANT    = VARIANT_B
)
(
  input wire logic           clk,
  input wire logic           rst,
  input wire logic           req_ready,
  input wire logic           rsp_valid,
  input wire sr_pkg::sr_pins_type pins,
  input wire logic           dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // assertions
  // ********************
  logic [19:0] up;
  always_ff @(posedge clk or posedge rst)
    if (rst) up <= 20'h0;
    else if (up != 20'hFFFFF) up <= up + 20'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_boot; up < POWERUP_CYCLES |-> !req_ready && pins.sel_n; endproperty
  a_boot: assert property (p_boot) else $error("early access");
  property p_ref; pins.ref_sel == REF_VARIANT; endproperty
  a_ref: assert property (p_ref) else $error("bad ref level");
  property p_rd; !pins.oe_n |-> pins.we_n && !pins.sel_n && !dq_oe; endproperty
  a_rd: assert property (p_rd) else $error("read pins");
  property p_rdlen; $fell(pins.oe_n) |-> ##50 rsp_valid && $rose(pins.oe_n); endproperty
  a_rdlen: assert property (p_rdlen) else $error("read length");
  property p_addr; !pins.sel_n && !$past(pins.sel_n) |-> $stable(pins.addr); endproperty
  a_addr: assert property (p_addr) else $error("addr moved");
  property p_wp; $fell(pins.we_n) |-> ##50 $rose(pins.we_n); endproperty
  a_wp: assert property (p_wp) else $error("strobe width");
  property p_wr; !pins.we_n |-> dq_oe && !pins.sel_n; endproperty
  a_wr: assert property (p_wr) else $error("write pins");
  property p_gap; $rose(pins.sel_n) |-> ##15 $rose(req_ready); endproperty
  a_gap: assert property (p_gap) else $error("float gap");
endmodule
bind sr_host sr_host_checker #(.POWERUP_CYCLES(POWERUP_CYCLES), .REF_VARIANT(REF_VARIANT))
  sr_host_checker_inst (.clk(clk), .rst(rst), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .pins(pins), .dq_oe(dq_oe));

/* File: test/sr_ram.sv */
/* 1K x 8 static RAM model; host resolves nothing, q is the wire level */
module sr_ram
  import sr_pkg::*;
(
  input  wire logic           clk,
  input  sr_pkg::sr_pins_type p,
  input  wire logic [7:0]     d,
  input  wire logic           oe,
  output logic [7:0]          q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // storage and bus
  // ********************
  logic [7:0] mem [1024];
  logic [7:0] junk = 8'hA5;
  wire rd = !p.sel_n && !p.oe_n && p.we_n && p.ref_sel == 1'b0;
  // released bus shows a moving pattern
  assign q = oe ? d : (rd ? mem[p.addr] : junk);
  always @(posedge clk) junk <= junk + 8'h5B;
  always @(posedge (p.sel_n | p.we_n)) mem[p.addr] = q;
endmodule

/* File: test/tb_sr_host.sv */
/* self-checking bench for sr_host; sr_ram stands on the pins */
module tb_sr_host;
  import sr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // bench
  // ********************
  logic        clk = 1'b0, rst = 1'b1, req_valid = 1'b0;
  sr_req_type  req = '0;
  logic        req_ready, rsp_valid, dq_oe;
  logic [7:0]  rsp_data, dq_out, dq_in;
  sr_pins_type pins;
  int          miscompares = 0, total_checks = 0;
  always #2 clk = ~clk;
  sr_host #(.POWERUP_CYCLES(10)) sr_host_inst (.clk(clk), .rst(rst), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  sr_ram sr_ram_inst (.clk(clk), .p(pins), .d(dq_out), .oe(dq_oe), .q(dq_in));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one request, held until taken; reads compared on rsp_valid
  task automatic access(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{w, a, d};
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    if (!w)
    begin
      while (rsp_valid !== 1'b1) @(negedge clk);
      check(rsp_data, d);
    end
  endtask
  task automatic t_boot;
    repeat (8) @(negedge clk);
    check({7'h0, req_ready}, 8'h00);
    repeat (4) @(negedge clk);
    check({7'h0, req_ready}, 8'h01);
    check({7'h0, pins.ref_sel}, 8'h00);
    check({7'h0, pins.sel_n}, 8'h01);
    check({7'h0, dq_oe}, 8'h00);
  endtask
  // edge addresses, rewrite then read straight after
  task automatic t_rw;
    access(1'b1, 10'h000, 8'hC3);
    access(1'b1, 10'h3FF, 8'h3D);
    access(1'b1, 10'h155, 8'h94);
    access(1'b1, 10'h3FF, 8'h3F);
    access(1'b0, 10'h3FF, 8'h3F);
    access(1'b0, 10'h000, 8'hC3);
    access(1'b0, 10'h155, 8'h94);
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_boot;
    t_rw;
    tally_and_finish;
  end
  initial
  begin
    #20000;
    miscompares++;
    tally_and_finish;
  end
endmodule
